// ### core_link_if.sv
/*
  Carrier between the CPU state block and its ALU and stop-recovery timer.
  Assumes all three sit on the same clock.
*/
`default_nettype none
interface core_link_if;
  import cpu_state_pkg::*;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  cmd_e alu_op;
  logic [7:0] alu_flags_in;
  logic [7:0] alu_r;
  logic [7:0] alu_flags_out;
  logic timer_start;
  logic timer_done;
  modport core (output alu_a, alu_b, alu_op, alu_flags_in, timer_start,
                input alu_r, alu_flags_out, timer_done);
  modport alu (input alu_a, alu_b, alu_op, alu_flags_in, output alu_r, alu_flags_out);
  modport timer (input timer_start, output timer_done);
endinterface
`default_nettype wire

// ### cpu_alu.sv
/*
  Combinational ALU: add, add with carry, subtract, and, shift left, load.
  Assumes the core applies the result and new flags in the same cycle.
*/
`default_nettype none
module cpu_alu import cpu_state_pkg::*; (
  core_link_if.alu lnk
);
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] half5;
  logic carry_in;
  logic v;
  logic h;
  logic c;
  logic [7:0] r;

  // Adder and subtractor paths
  assign carry_in = (lnk.alu_op == CMD_ADC) & lnk.alu_flags_in[FLG_C];
  assign sum9 = {1'b0, lnk.alu_a} + {1'b0, lnk.alu_b} + {8'h00, carry_in};
  assign half5 = {1'b0, lnk.alu_a[3:0]} + {1'b0, lnk.alu_b[3:0]} + {4'h0, carry_in};
  assign diff9 = {1'b0, lnk.alu_a} - {1'b0, lnk.alu_b};

  // Result and flag selection per operation
  always_comb begin
    r = lnk.alu_b;
    v = 1'b0;
    h = lnk.alu_flags_in[FLG_H];
    c = lnk.alu_flags_in[FLG_C];
    case (lnk.alu_op)
      CMD_ADD, CMD_ADC: begin
        r = sum9[7:0];
        c = sum9[8];
        h = half5[4];
        v = (lnk.alu_a[7] == lnk.alu_b[7]) && (sum9[7] != lnk.alu_a[7]);
      end
      CMD_SUB: begin
        r = diff9[7:0];
        c = diff9[8];
        v = (lnk.alu_a[7] != lnk.alu_b[7]) && (diff9[7] != lnk.alu_a[7]);
      end
      CMD_AND: r = lnk.alu_a & lnk.alu_b;
      CMD_SHL: begin
        r = {lnk.alu_a[6:0], 1'b0};
        c = lnk.alu_a[7];
        v = lnk.alu_a[7] ^ lnk.alu_a[6];
      end
      default: r = lnk.alu_b;
    endcase
  end

  // Negative and zero follow every result
  assign lnk.alu_r = r;
  assign lnk.alu_flags_out = {v, 2'b11, h, lnk.alu_flags_in[FLG_I], r[7], (r == 8'h00), c};
endmodule
`default_nettype wire

// ### cpu_state_and_flags.sv
/*
  Programmer-visible CPU state: accumulator, index pair, stack top, fetch
  address, condition flags, plus interrupt, wait, stop and break sequencing.
  Assumes Avalon-MM register access on mclk and a memory bus whose read data
  is valid in the same cycle as the read strobe.
*/
`default_nettype none
// Summary of operation
// - Accumulator is an 8-bit register taking arithmetic and logic results.
// - Index pair is a 16-bit value of high and low bytes.
// - Reset sets stack top to 00FF.
// - Stack reinit command sets stack low byte to FF, keeps high byte.
// - Each pushed byte decrements stack top, each pulled byte increments it.
// - Fetch address increments per fetch; jumps and interrupts load new address.
// - After reset fetch address loads from vector at FFFE high, FFFF low.
// - Flag bits 6 and 5 always read one.
// - Overflow flag shows two's complement overflow, cleared otherwise.
// - Half-carry flag shows carry from bit 3 to bit 4 on adds.
// - Mask blocks maskable interrupts; entry sets mask after stacking, before vector.
// - Interrupt entry does not stack the index high byte.
// - Return from trap pulls registers and restores mask from stack.
// - Reset sets the mask; the unmask, wait and stop commands clear it, return from trap reloads it.
// - Negative flag copies bit 7 of each result.
// - Zero flag set for a zero result, cleared otherwise.
// - Carry flag shows add carry out, subtract borrow, and shift out.
// - Wait clears mask and stops clock; interrupt wake keeps mask clear.
// - Stop clears mask, stops clock, restarts after stabilisation delay.
// - Break loads trap opcode and vector FFFC, or FEFC in monitor mode.
// - Break starts after the current instruction, or at once on final-cycle match; the code takes the match only on the last cycle of a pull.
// - Return from trap ends break handling once the break request is gone.
module cpu_state_and_flags import cpu_state_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_write,
  output logic mem_read,
  input wire logic [7:0] mem_rdata,
  input wire logic irq_request,
  input wire logic break_request,
  input wire logic break_match_last,
  input wire logic monitor_mode,
  output logic cpu_clock_run,
  output logic break_active
);
  core_link_if lnk ();

  logic [7:0] acc;
  logic [15:0] index_pair;
  logic [15:0] stack_top;
  logic [15:0] fetch_address;
  logic [7:0] flags;
  logic [7:0] instr;
  state_e state;
  logic [2:0] step;
  logic [15:0] vec_base;
  logic bus_ack;
  logic [7:0] next_acc;
  logic [15:0] next_index;
  logic [15:0] next_stack;
  logic [15:0] next_fetch;
  logic [7:0] next_flags;
  logic [7:0] next_instr;
  state_e next_state;
  logic [2:0] next_step;
  logic [15:0] next_vec;
  logic next_in_break;

  // Register bus handshake: one wait cycle for every access
  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & bus_ack;
  wire is_idle = (state == S_IDLE);
  wire reg_wr = wr_fire & is_idle;
  wire cmd_e cmd_code = cmd_e'(avs_writedata[3:0]);
  wire [7:0] cmd_operand = avs_writedata[15:8];
  wire [15:0] break_vec = monitor_mode ? VEC_BREAK_MON : VEC_BREAK;
  wire take_break = is_idle & break_request & ~break_active;
  wire take_irq = is_idle & irq_request & ~flags[FLG_I];
  wire cmd_go = wr_fire & (avs_address == OFS_CMD) & is_idle & ~take_break & ~take_irq;
  wire pull_last = (step == STEP_LAST_FRAME) | (step == STEP_INDEX_HIGH);
  wire [15:0] vec_addr = (state == S_VECL) ? vec_base + 16'h0001 : vec_base;
  assign avs_waitrequest = bus_req & ~bus_ack;

  // Read-back selection; unmapped offsets read zero
  wire [31:0] status_word = {22'h00_0000, break_active, cpu_clock_run, state};
  wire [31:0] read_mux =
    (avs_address == OFS_ACC) ? {24'h00_0000, acc} :
    (avs_address == OFS_INDEX) ? {16'h0000, index_pair} :
    (avs_address == OFS_STACK) ? {16'h0000, stack_top} :
    (avs_address == OFS_FETCH) ? {16'h0000, fetch_address} :
    (avs_address == OFS_FLAGS) ? {24'h00_0000, flags} :
    (avs_address == OFS_STATUS) ? status_word :
    (avs_address == OFS_INSTR) ? {24'h00_0000, instr} : 32'h0000_0000;

  // Byte order of the stacked frame, index high only for its own push
  wire [7:0] push_byte =
    (step == STEP_INDEX_HIGH) ? index_pair[15:8] :
    (step == 3'h4) ? fetch_address[7:0] :
    (step == 3'h3) ? fetch_address[15:8] :
    (step == 3'h2) ? index_pair[7:0] :
    (step == 3'h1) ? acc : flags;

  // Memory bus driven from the sequencer state
  assign mem_write = (state == S_PUSH);
  assign mem_read = (state == S_PULL) | (state == S_VECH) | (state == S_VECL);
  assign mem_wdata = push_byte;
  assign mem_addr = (state == S_PUSH) ? stack_top :
                    (state == S_PULL) ? stack_top + 16'h0001 : vec_addr;

  // Clock gating indication while waiting or stopped
  assign cpu_clock_run = ~((state == S_WAIT) | (state == S_STOP) | (state == S_RECOVER));

  // ALU and timer hookup
  assign lnk.alu_a = acc;
  assign lnk.alu_b = cmd_operand;
  assign lnk.alu_op = cmd_code;
  assign lnk.alu_flags_in = flags;
  assign lnk.timer_start = (state == S_STOP) & irq_request;

  cpu_alu u_alu (
    .lnk(lnk.alu)
  );

  stop_recovery_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .lnk(lnk.timer)
  );

  // Next-state and register update logic
  always_comb begin
    next_acc = acc;
    next_index = index_pair;
    next_stack = stack_top;
    next_fetch = fetch_address;
    next_flags = flags;
    next_instr = instr;
    next_state = state;
    next_step = step;
    next_vec = vec_base;
    next_in_break = break_active;
    case (state)
      S_IDLE: begin
        if (take_break) begin
          next_instr = TRAP_OPCODE;
          next_vec = break_vec;
          next_in_break = 1'b1;
          next_state = S_PUSH;
          next_step = STEP_LAST_FRAME;
        end else if (take_irq) begin
          next_vec = VEC_IRQ;
          next_state = S_PUSH;
          next_step = STEP_LAST_FRAME;
        end else if (cmd_go) begin
          case (cmd_code)
            CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND, CMD_SHL, CMD_LOAD: begin
              next_acc = lnk.alu_r;
              next_flags = lnk.alu_flags_out;
            end
            CMD_FETCH: next_fetch = fetch_address + 16'h0001;
            CMD_JUMP: next_fetch = index_pair;
            CMD_PUSH_H: begin
              next_state = S_PUSH;
              next_step = STEP_INDEX_HIGH;
            end
            CMD_PULL_H: begin
              next_state = S_PULL;
              next_step = STEP_INDEX_HIGH;
            end
            CMD_RSP: next_stack = {stack_top[15:8], STACK_LOW_ONES};
            CMD_CLI: next_flags[FLG_I] = 1'b0;
            CMD_RTI: begin
              next_state = S_PULL;
              next_step = STEP_FIRST;
            end
            CMD_WAIT: begin
              next_flags[FLG_I] = 1'b0;
              next_state = S_WAIT;
            end
            CMD_STOP: begin
              next_flags[FLG_I] = 1'b0;
              next_state = S_STOP;
            end
            default: next_state = S_IDLE;
          endcase
        end else if (reg_wr) begin
          // Direct software writes; the mask bit is never written this way
          if (avs_address == OFS_ACC) next_acc = avs_writedata[7:0];
          if (avs_address == OFS_INDEX) next_index = avs_writedata[15:0];
          if (avs_address == OFS_STACK) next_stack = avs_writedata[15:0];
          if (avs_address == OFS_FETCH) next_fetch = avs_writedata[15:0];
          if (avs_address == OFS_FLAGS) next_flags = {avs_writedata[7:4], flags[FLG_I], avs_writedata[2:0]};
        end
      end
      S_PUSH: begin
        next_stack = stack_top - 16'h0001;
        if (step == STEP_INDEX_HIGH) begin
          next_state = S_IDLE;
        end else if (step == STEP_FIRST) begin
          next_flags[FLG_I] = 1'b1;
          next_state = S_VECH;
        end else begin
          next_step = step - 3'h1;
        end
      end
      S_PULL: begin
        next_stack = stack_top + 16'h0001;
        case (step)
          3'h0: next_flags = mem_rdata;
          3'h1: next_acc = mem_rdata;
          3'h2: next_index[7:0] = mem_rdata;
          3'h3: next_fetch[15:8] = mem_rdata;
          3'h4: next_fetch[7:0] = mem_rdata;
          default: next_index[15:8] = mem_rdata;
        endcase
        if (pull_last) begin
          next_state = S_IDLE;
          if (step == STEP_LAST_FRAME && break_active && !break_request) begin
            next_in_break = 1'b0;
          end
          if (break_match_last && !(break_active && break_request)) begin
            // Match on the final cycle: break entry with no idle cycle
            next_instr = TRAP_OPCODE;
            next_vec = break_vec;
            next_in_break = 1'b1;
            next_state = S_PUSH;
            next_step = STEP_LAST_FRAME;
          end
        end else begin
          next_step = step + 3'h1;
        end
      end
      S_VECH: begin
        next_fetch[15:8] = mem_rdata;
        next_state = S_VECL;
      end
      S_VECL: begin
        next_fetch[7:0] = mem_rdata;
        next_state = S_IDLE;
      end
      S_WAIT: begin
        // Interrupt wake: mask stays clear until the entry sequence sets it
        if (irq_request) begin
          next_vec = VEC_IRQ;
          next_state = S_PUSH;
          next_step = STEP_LAST_FRAME;
        end
      end
      S_STOP: begin
        if (irq_request) next_state = S_RECOVER;
      end
      S_RECOVER: begin
        if (lnk.timer_done) begin
          next_vec = VEC_IRQ;
          next_state = S_PUSH;
          next_step = STEP_LAST_FRAME;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // State registers; reset sets mask and starts the reset vector fetch
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc <= 8'h00;
      index_pair <= 16'h0000;
      stack_top <= STACK_RESET;
      fetch_address <= 16'h0000;
      flags <= FLAGS_RESET;
      instr <= 8'h00;
      state <= S_VECH;
      step <= STEP_FIRST;
      vec_base <= VEC_RESET;
      break_active <= 1'b0;
    end else begin
      acc <= next_acc;
      index_pair <= next_index;
      stack_top <= next_stack;
      fetch_address <= next_fetch;
      flags <= next_flags | FIXED_ONES;
      instr <= next_instr;
      state <= next_state;
      step <= next_step;
      vec_base <= next_vec;
      break_active <= next_in_break;
    end
  end

  // Bus answer registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read & ~bus_ack) avs_readdata <= read_mux;
    end
  end

  AST_STACK_RESET: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> stack_top == STACK_RESET) else $error("stack top not 00FF after reset");

  AST_RESET_VECTOR: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> (mem_read && mem_addr == VEC_RESET && flags[FLG_I])
      ##1 (mem_read && mem_addr == VEC_RESET + 16'h0001)) else $error("reset vector fetch wrong");

  AST_STACK_REINIT: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == CMD_RSP) |=> (stack_top[7:0] == STACK_LOW_ONES)
      && (stack_top[15:8] == $past(stack_top[15:8]))) else $error("stack reinit wrong");

  AST_PUSH_PULL: assert property (@(posedge mclk) disable iff (reset)
    (mem_write |=> stack_top == $past(stack_top) - 16'h0001)
      and ((state == S_PULL) |=> stack_top == $past(stack_top) + 16'h0001)) else $error("stack step wrong");

  AST_FETCH_STEP: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == CMD_FETCH) |=> fetch_address == $past(fetch_address) + 16'h0001)
    else $error("fetch address did not advance");

  AST_FIXED_BITS: assert property (@(posedge mclk) disable iff (reset)
    flags[6:5] == 2'b11) else $error("fixed flag bits not one");

  AST_ADD_FLAGS: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == CMD_ADD) |=> (flags[FLG_V] == (($past(acc[7]) == $past(cmd_operand[7]))
      && (acc[7] != $past(acc[7])))) && (flags[1] == (acc == 8'h00))) else $error("add flags wrong");

  AST_MASK_ORDER: assert property (@(posedge mclk) disable iff (reset)
    (state == S_PUSH && step == STEP_FIRST) |-> !flags[FLG_I] || $past(flags[FLG_I])
      ##1 (state == S_VECH && flags[FLG_I])) else $error("mask not set between stacking and vector");

  AST_WAIT_ENTRY: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == CMD_WAIT) |=> (!flags[FLG_I] && !cpu_clock_run)) else $error("wait entry wrong");

  AST_HOLD_STOPPED: assert property (@(posedge mclk) disable iff (reset)
    (!cpu_clock_run && !$past(cpu_clock_run)) |-> ($stable(acc) && $stable(index_pair)
      && $stable(stack_top) && $stable(fetch_address))) else $error("registers changed while stopped");

  AST_BREAK_ENTRY: assert property (@(posedge mclk) disable iff (reset)
    take_break |=> (instr == TRAP_OPCODE) && (vec_base == $past(break_vec)) && break_active)
    else $error("break entry wrong");
endmodule
`default_nettype wire

// ### cpu_state_pkg.sv
/*
  Shared constants and types for the CPU programmer-visible state block:
  register offsets, flag positions, reset values, vectors, commands, states.
  Assumes a byte-addressed 32-bit register bus and an 8-bit memory bus.
*/
`default_nettype none
package cpu_state_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_STACK = 8'h08;
  localparam logic [7:0] OFS_FETCH = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_INSTR = 8'h1c;
  // Flag bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_C = 0;
  localparam logic [7:0] FIXED_ONES = 8'h60;
  // Reset values and vectors
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [7:0] STACK_LOW_ONES = 8'hff;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_BREAK = 16'hfffc;
  localparam logic [15:0] VEC_BREAK_MON = 16'hfefc;
  localparam logic [15:0] VEC_IRQ = 16'hfff0;
  localparam logic [7:0] TRAP_OPCODE = 8'ha5;
  // Sequence step codes
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_LAST_FRAME = 3'h4;
  localparam logic [2:0] STEP_INDEX_HIGH = 3'h5;
  // Stop recovery delay in clock cycles
  localparam int STOP_RECOVERY_CYCLES = 4096;
  // Commands written to the command register
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ADD = 4'h1, CMD_ADC = 4'h2, CMD_SUB = 4'h3,
    CMD_AND = 4'h4, CMD_SHL = 4'h5, CMD_LOAD = 4'h6, CMD_FETCH = 4'h7,
    CMD_JUMP = 4'h8, CMD_PUSH_H = 4'h9, CMD_PULL_H = 4'ha, CMD_RSP = 4'hb,
    CMD_CLI = 4'hc, CMD_RTI = 4'hd, CMD_WAIT = 4'he, CMD_STOP = 4'hf
  } cmd_e;
  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_PUSH = 8'h02, S_PULL = 8'h04, S_VECH = 8'h08,
    S_VECL = 8'h10, S_WAIT = 8'h20, S_STOP = 8'h40, S_RECOVER = 8'h80
  } state_e;
endpackage
`default_nettype wire

// ### mem_model.sv
/*
  Byte memory answering the CPU state block's memory bus.
  Assumes read data are wanted in the same cycle as the read strobe.
*/
`default_nettype none
module mem_model (
  input wire logic mclk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_write,
  input wire logic mem_read,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [0:65535];
  logic [7:0] last = 8'h00;
  // Pattern fill, so every vector differs
  initial begin
    for (int i = 0; i < 65536; i++) begin
      m[i] = i[15:8] ^ i[7:0];
    end
  end
  // One byte per strobe cycle
  always @(posedge mclk) begin
    if (mem_write) m[mem_addr] <= mem_wdata;
    if (mem_read) last <= m[mem_addr];
  end
  // Released bus shows inverse of last byte
  assign mem_rdata = mem_read ? m[mem_addr] : ~last;
endmodule
`default_nettype wire

// ### stop_recovery_timer.sv
/*
  Oscillator stabilisation delay after a stop-mode wake-up.
  Assumes start is a one-cycle pulse; done pulses once when the delay ends.
*/
`default_nettype none
module stop_recovery_timer import cpu_state_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  core_link_if.timer lnk
);
  logic [12:0] count;
  logic running;

  // Down-counter loaded on start
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= 13'h0000;
      running <= 1'b0;
    end else if (lnk.timer_start) begin
      count <= 13'(STOP_RECOVERY_CYCLES);
      running <= 1'b1;
    end else if (running) begin
      count <= count - 13'h0001;
      running <= (count != 13'h0001);
    end
  end

  assign lnk.timer_done = running && (count == 13'h0001);
endmodule
`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench for cpu_state_and_flags over Avalon-MM.
  Assumes mem_model on the memory bus; the bench drives the break-address match.
*/
`default_nettype none
module testbench import cpu_state_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, avs_read = 0, avs_write = 0, irq_request = 0, break_request = 0, monitor_mode = 0;
  logic break_match_last = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, mem_write, mem_read, cpu_clock_run, break_active;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] rnd = 8'h17;
  logic [31:0] exp_q[$], msk_q[$];
  int err_count = 0, n_checks = 0;
  cpu_state_and_flags dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
    .mem_read(mem_read), .mem_rdata(mem_rdata), .irq_request(irq_request), .break_request(break_request),
    .break_match_last(break_match_last), .monitor_mode(monitor_mode), .cpu_clock_run(cpu_clock_run),
    .break_active(break_active));
  mem_model mm (.mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
    .mem_read(mem_read), .mem_rdata(mem_rdata));
  // Clock
  initial forever #5 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Avalon cycle, held until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k = 32'hffff_ffff);
    exp_q.push_back(e & k);
    msk_q.push_back(k);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cmd(input cmd_e c, input logic [7:0] op = 8'h00, input int w = 12);
    bus(1'b1, OFS_CMD, {16'h0000, op, 4'h0, c});
    repeat (w) @(posedge mclk);
  endtask
  task automatic irq_pulse;
    irq_request <= 1'b1;
    repeat (10) @(posedge mclk);
    irq_request <= 1'b0;
  endtask
  function automatic logic [31:0] vec(input logic [15:0] a);
    return {16'h0000, a[15:8] ^ a[7:0], a[15:8] ^ a[7:0] ^ 8'h01};
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Each read answer is compared with the oldest note
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // Watchdog
  initial begin
    #300000;
    err_count++;
    end_of_test();
  end
  initial begin
    logic [7:0] a, b, r;
    logic [8:0] s;
    int n;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(OFS_STACK, 32'h0000_00ff);
    rd(OFS_FLAGS, 32'h0000_0068);
    rd(OFS_FETCH, vec(16'hfffe));
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : rnd;
      b = (i < 2) ? 8'h01 : nxt(rnd);
      rnd = nxt(nxt(rnd));
      s = a + b;
      r = s[7:0];
      cmd(CMD_LOAD, a);
      cmd(CMD_ADD, b);
      rd(OFS_ACC, {24'h0, r});
      rd(OFS_FLAGS, {24'h0, (a[7] == b[7]) && (r[7] != a[7]), 2'b11, ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'd15,
        1'b1, r[7], r == 8'h00, s[8]});
    end
    cmd(CMD_LOAD, 8'h01);
    cmd(CMD_SUB, 8'h81);
    rd(OFS_FLAGS, 32'h0000_0085, 32'h0000_0087);
    cmd(CMD_LOAD, 8'hf0);
    cmd(CMD_AND, 8'h0f);
    rd(OFS_FLAGS, 32'h0000_0002, 32'h0000_0086);
    cmd(CMD_LOAD, 8'h81);
    cmd(CMD_SHL);
    rd(OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
    cmd(CMD_ADC, 8'h0f);
    rd(OFS_ACC, 32'h0000_0012);
    rd(OFS_FLAGS, 32'h0000_0078);
    bus(1'b1, OFS_FLAGS, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0068, 32'h0000_0068);
    $display("flags done");
    bus(1'b1, OFS_STACK, 32'h0000_1234);
    cmd(CMD_RSP);
    rd(OFS_STACK, 32'h0000_12ff);
    bus(1'b1, OFS_STACK, 32'h0000_0180);
    bus(1'b1, OFS_INDEX, 32'h0000_ab12);
    cmd(CMD_PUSH_H);
    rd(OFS_STACK, 32'h0000_017f);
    check({24'h0, mm.m[16'h0180]}, 32'h0000_00ab);
    bus(1'b1, OFS_INDEX, 32'h0000_0000);
    cmd(CMD_PULL_H);
    rd(OFS_INDEX, 32'h0000_ab00);
    rd(OFS_STACK, 32'h0000_0180);
    cmd(CMD_JUMP);
    cmd(CMD_FETCH);
    rd(OFS_FETCH, 32'h0000_ab01);
    $display("stack and fetch done");
    cmd(CMD_LOAD, 8'h3c);
    cmd(CMD_CLI);
    rd(OFS_FLAGS, 32'h0000_0000, 32'h0000_0008);
    irq_pulse();
    rd(OFS_FETCH, vec(16'hfff0));
    rd(OFS_FLAGS, 32'h0000_0008, 32'h0000_0008);
    rd(OFS_STACK, 32'h0000_017b);
    check({mm.m[16'h0180], mm.m[16'h017f], mm.m[16'h017e], mm.m[16'h017d]}, 32'h01ab_003c);
    cmd(CMD_WAIT, 8'h00, 3);
    check({31'h0, cpu_clock_run}, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0020);
    rd(OFS_FLAGS, 32'h0000_0000, 32'h0000_0008);
    rd(OFS_ACC, 32'h0000_003c);
    irq_pulse();
    check({24'h0, mm.m[16'h0177] & 8'h08}, 32'h0000_0000);
    cmd(CMD_RTI);
    cmd(CMD_RTI);
    rd(OFS_STACK, 32'h0000_0180);
    rd(OFS_FLAGS, 32'h0000_0000, 32'h0000_0008);
    rd(OFS_FETCH, 32'h0000_ab01);
    $display("interrupt and wait done");
    cmd(CMD_STOP, 8'h00, 3);
    rd(OFS_STATUS, 32'h0000_0040);
    irq_request <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cpu_clock_run !== 1'b1 && n < 5000);
    check(32'(n > 4000 && n < 5000), 32'h0000_0001);
    repeat (10) @(posedge mclk);
    irq_request <= 1'b0;
    check({24'h0, mm.m[16'h017c] & 8'h08}, 32'h0000_0000);
    rd(OFS_ACC, 32'h0000_003c);
    cmd(CMD_RTI);
    $display("stop done");
    for (int k = 0; k < 2; k++) begin
      monitor_mode <= k[0];
      break_request <= 1'b1;
      repeat (10) @(posedge mclk);
      rd(OFS_STATUS, 32'h0000_0200, 32'h0000_0200);
      rd(OFS_INSTR, {24'h0, TRAP_OPCODE});
      rd(OFS_FETCH, vec(k ? 16'hfefc : 16'hfffc));
      cmd(CMD_RTI);
      check({31'h0, break_active}, 32'h0000_0001);
      break_request <= 1'b0;
      cmd(CMD_RTI);
      check({31'h0, break_active}, 32'h0000_0000);
    end
    break_match_last <= 1'b1;
    cmd(CMD_PULL_H);
    break_match_last <= 1'b0;
    rd(OFS_FETCH, vec(16'hfefc));
    rd(OFS_STATUS, 32'h0000_0200, 32'h0000_0200);
    cmd(CMD_RTI);
    check({31'h0, break_active}, 32'h0000_0000);
    $display("break done");
    repeat (4) @(posedge mclk);
    check(32'(exp_q.size()), 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
